// *** tap_consts.svh ***
// Constants for the boundary-scan test access port.
`ifndef TAP_CONSTS_SVH
`define TAP_CONSTS_SVH

// ============================================================
// Instruction register
`define TAP_IR_W 2
`define TAP_IR_EXTEST 2'h0
`define TAP_IR_SAMPLE_A 2'h1
`define TAP_IR_SAMPLE_B 2'h2
`define TAP_IR_BYPASS 2'h3
`define TAP_IR_CAPTURE 2'h1
`define TAP_IR_RESET 2'h3

// ============================================================
// Boundary-scan register, cell k sits at index k-1
`define TAP_BSR_N 107
`define TAP_CELL_IRQ_EN 57
`define TAP_CELL_ACK_OUT 59

// ============================================================
// Synchroniser reset levels
`define TAP_PULL_LEVEL 1'h1
`define TAP_CLK_IDLE 1'h0

// ============================================================
// Snapshot buffer
`define TAP_FIFO_DEPTH 16

`endif

// *** tap_pkg.sv ***
// Types shared by the boundary-scan test access port.
package tap_pkg;

  // ============================================================
  // Controller states
  typedef enum logic [3:0] {
    test_logic_reset, run_idle,
    select_dr, capture_dr, shift_dr, exit1_dr, pause_dr, exit2_dr,
    update_dr,
    select_ir, capture_ir, shift_ir, exit1_ir, pause_ir, exit2_ir,
    update_ir
  } tap_state_t;

endpackage : tap_pkg

// *** stream_if.sv ***
// Valid and ready stream carrier between the controller and its buffer.
`timescale 1ns/1ps
interface stream_if #(
  parameter int W = 107
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  modport buffer (
    input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data
  );
  modport user (
    output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data
  );
endinterface : stream_if

// *** snap_fifo.sv ***
// First-in first-out buffer with valid and ready on both sides.
`timescale 1ns/1ps
module snap_fifo #(
  parameter int W = 107,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Stream
  stream_if.buffer s
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d;
  logic [AW:0] rd_q, rd_d;
  logic [AW:0] used;
  logic push;
  logic pop;

  // ============================================================
  // Occupancy
  assign used = wr_q - rd_q;
  assign s.in_ready = (used != (AW+1)'(DEPTH));
  assign s.out_valid = (used != '0);
  assign s.out_data = mem_q[rd_q[AW-1:0]];
  assign push = s.in_valid & s.in_ready;
  assign pop = s.out_valid & s.out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // ============================================================
  // Storage, written only when a slot is free
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= s.in_data;
    end
  end
endmodule : snap_fifo

// *** boundary_scan_tap.sv ***
// Boundary-scan test access port with controller, instruction and data paths.
// Operation
// - Test logic runs from test clock only; code clocks it from mclk and acts on synchronised test clock edges.
// - Mode select sampled each test clock rise.
// - Undriven select, data, reset read high.
// - Data input shifts into selected register.
// - Data output changes on test clock fall.
// - Output driver off when not shifting.
// - Test reset forces reset state asynchronously.
// - Two-bit instruction shifted during Shift-IR.
// - Instruction picks active data register path.
// - Code 00 drives pins from cells.
// - Codes 01, 10 sample and preload.
// - Code 11 selects one-bit bypass path.
// - Test reset loads bypass instruction.
// - Bypass register is one flip-flop.
// - Boundary register holds 107 cells.
// - Cell 1 is shifted out first.
// - Enable cells active high; zeros tristate; code holds IRQ enable index 57 high.
// - Bidirectional pins use enable, output, input.
`timescale 1ns/1ps
`include "tap_consts.svh"
module boundary_scan_tap #(
  parameter int BSR_N = `TAP_BSR_N,
  parameter int FIFO_DEPTH = `TAP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Test access port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  // Boundary cells, core side in and pad side out
  input wire logic [BSR_N-1:0] core_cells,
  output logic [BSR_N-1:0] pad_cells,
  output logic ack_oe,
  output logic test_mode,
  // Sample snapshot stream
  output logic snap_valid,
  input wire logic snap_ready,
  output logic [BSR_N-1:0] snap_data
);

  // ============================================================
  // Pin synchronisers
  logic tck_s1_q, tck_s2_q, tck_prev_q;
  logic tms_s1_q, tms_s2_q;
  logic tdi_s1_q, tdi_s2_q;
  logic tck_rise;
  logic tck_fall;
  logic tap_rst;

  // The test reset pin acts as an asynchronous reset of the controller.
  assign tap_rst = reset | ~trst_n;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tck_s1_q <= `TAP_CLK_IDLE;
      tck_s2_q <= `TAP_CLK_IDLE;
      tck_prev_q <= `TAP_CLK_IDLE;
      tms_s1_q <= `TAP_PULL_LEVEL;
      tms_s2_q <= `TAP_PULL_LEVEL;
      tdi_s1_q <= `TAP_PULL_LEVEL;
      tdi_s2_q <= `TAP_PULL_LEVEL;
    end else begin
      tck_s1_q <= tck;
      tck_s2_q <= tck_s1_q;
      tck_prev_q <= tck_s2_q;
      tms_s1_q <= tms;
      tms_s2_q <= tms_s1_q;
      tdi_s1_q <= tdi;
      tdi_s2_q <= tdi_s1_q;
    end
  end

  // The controller, instruction and data registers advance only on edges of the test clock.
  assign tck_rise = tck_s2_q & ~tck_prev_q;
  assign tck_fall = ~tck_s2_q & tck_prev_q;

  // ============================================================
  // Controller next state
  function automatic tap_pkg::tap_state_t next_state(
    input tap_pkg::tap_state_t st,
    input logic m
  );
    unique case (st)
      tap_pkg::test_logic_reset:
        next_state = m ? tap_pkg::test_logic_reset : tap_pkg::run_idle;
      tap_pkg::run_idle:
        next_state = m ? tap_pkg::select_dr : tap_pkg::run_idle;
      tap_pkg::select_dr:
        next_state = m ? tap_pkg::select_ir : tap_pkg::capture_dr;
      tap_pkg::capture_dr:
        next_state = m ? tap_pkg::exit1_dr : tap_pkg::shift_dr;
      tap_pkg::shift_dr:
        next_state = m ? tap_pkg::exit1_dr : tap_pkg::shift_dr;
      tap_pkg::exit1_dr:
        next_state = m ? tap_pkg::update_dr : tap_pkg::pause_dr;
      tap_pkg::pause_dr:
        next_state = m ? tap_pkg::exit2_dr : tap_pkg::pause_dr;
      tap_pkg::exit2_dr:
        next_state = m ? tap_pkg::update_dr : tap_pkg::shift_dr;
      tap_pkg::update_dr:
        next_state = m ? tap_pkg::select_dr : tap_pkg::run_idle;
      tap_pkg::select_ir:
        next_state = m ? tap_pkg::test_logic_reset : tap_pkg::capture_ir;
      tap_pkg::capture_ir:
        next_state = m ? tap_pkg::exit1_ir : tap_pkg::shift_ir;
      tap_pkg::shift_ir:
        next_state = m ? tap_pkg::exit1_ir : tap_pkg::shift_ir;
      tap_pkg::exit1_ir:
        next_state = m ? tap_pkg::update_ir : tap_pkg::pause_ir;
      tap_pkg::pause_ir:
        next_state = m ? tap_pkg::exit2_ir : tap_pkg::pause_ir;
      tap_pkg::exit2_ir:
        next_state = m ? tap_pkg::update_ir : tap_pkg::shift_ir;
      tap_pkg::update_ir:
        next_state = m ? tap_pkg::select_dr : tap_pkg::run_idle;
    endcase
  endfunction : next_state

  // ============================================================
  // Controller, instruction and data registers
  tap_pkg::tap_state_t st_q, st_d;
  logic [`TAP_IR_W-1:0] ir_sh_q, ir_sh_d;
  logic [`TAP_IR_W-1:0] ir_q, ir_d;
  logic [BSR_N-1:0] bsr_q, bsr_d;
  logic [BSR_N-1:0] upd_q, upd_d;
  logic byp_q, byp_d;
  logic tdo_q, tdo_d;
  logic oe_q, oe_d;
  logic pend_q, pend_d;
  logic [BSR_N-1:0] snap_q, snap_d;
  logic bsr_sel;
  logic sampling;
  logic extest;

  assign extest = (ir_q == `TAP_IR_EXTEST);
  assign sampling = (ir_q == `TAP_IR_SAMPLE_A) |
                    (ir_q == `TAP_IR_SAMPLE_B);
  // Bypass is the only code that leaves the boundary chain out.
  assign bsr_sel = (ir_q != `TAP_IR_BYPASS);

  stream_if #(.W(BSR_N)) snap_s ();

  always_comb begin
    st_d = st_q;
    ir_sh_d = ir_sh_q;
    ir_d = ir_q;
    bsr_d = bsr_q;
    upd_d = upd_q;
    byp_d = byp_q;
    tdo_d = tdo_q;
    oe_d = oe_q;
    snap_d = snap_q;
    pend_d = pend_q;
    // A pending snapshot waits here until the buffer takes it.
    if (pend_q && snap_s.in_ready) begin
      pend_d = 1'b0;
    end
    if (tck_rise) begin
      st_d = next_state(st_q, tms_s2_q);
      unique case (st_q)
        tap_pkg::test_logic_reset: begin
          ir_d = `TAP_IR_RESET;
        end
        tap_pkg::capture_ir: begin
          ir_sh_d = `TAP_IR_CAPTURE;
        end
        tap_pkg::shift_ir: begin
          ir_sh_d = {tdi_s2_q, ir_sh_q[`TAP_IR_W-1:1]};
        end
        tap_pkg::update_ir: begin
          ir_d = ir_sh_q;
        end
        tap_pkg::capture_dr: begin
          if (bsr_sel) begin
            bsr_d = core_cells;
            if (sampling) begin
              snap_d = core_cells;
              pend_d = 1'b1;
            end
          end else begin
            byp_d = 1'b0;
          end
        end
        tap_pkg::shift_dr: begin
          if (bsr_sel) begin
            bsr_d = {tdi_s2_q, bsr_q[BSR_N-1:1]};
          end else begin
            byp_d = tdi_s2_q;
          end
        end
        tap_pkg::update_dr: begin
          if (bsr_sel) begin
            upd_d = bsr_q;
          end
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      oe_d = (st_q == tap_pkg::shift_ir) |
             (st_q == tap_pkg::shift_dr);
      if (st_q == tap_pkg::shift_ir) begin
        tdo_d = ir_sh_q[0];
      end else if (st_q == tap_pkg::shift_dr) begin
        tdo_d = bsr_sel ? bsr_q[0] : byp_q;
      end
    end
  end

  always_ff @(posedge mclk or posedge tap_rst) begin
    if (tap_rst) begin
      st_q <= tap_pkg::test_logic_reset;
      ir_sh_q <= `TAP_IR_RESET;
      ir_q <= `TAP_IR_RESET;
      bsr_q <= '0;
      upd_q <= '0;
      byp_q <= 1'b0;
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
      pend_q <= 1'b0;
      snap_q <= '0;
    end else begin
      st_q <= st_d;
      ir_sh_q <= ir_sh_d;
      ir_q <= ir_d;
      bsr_q <= bsr_d;
      upd_q <= upd_d;
      byp_q <= byp_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
      pend_q <= pend_d;
      snap_q <= snap_d;
    end
  end

  // ============================================================
  // Pad side of the boundary cells
  logic [BSR_N-1:0] pad_q, pad_d;
  logic ack_oe_q, ack_oe_d;
  logic test_q, test_d;

  always_comb begin
    // Under test the pins follow the update latches, else the core.
    // Enable cells are active high, so an all-zero load tristates all but the IRQ enable cell, which is forced high.
    pad_d = extest ? upd_q : core_cells;
    pad_d[`TAP_CELL_IRQ_EN] = 1'b1;
    // The acknowledge pin only ever pulls low.
    ack_oe_d = ~pad_d[`TAP_CELL_ACK_OUT];
    test_d = extest;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pad_q <= '0;
      ack_oe_q <= 1'b0;
      test_q <= 1'b0;
    end else begin
      pad_q <= pad_d;
      ack_oe_q <= ack_oe_d;
      test_q <= test_d;
    end
  end

  // ============================================================
  // Snapshot buffer
  logic head_q, head_d;
  logic [BSR_N-1:0] word_q, word_d;
  logic take;

  assign snap_s.in_valid = pend_q;
  assign snap_s.in_data = snap_q;
  // The head word moves into the output stage whenever that stage is free.
  assign take = snap_s.out_valid & (~head_q | snap_ready);
  assign snap_s.out_ready = ~head_q | snap_ready;

  always_comb begin
    head_d = head_q;
    word_d = word_q;
    if (take) begin
      head_d = 1'b1;
      word_d = snap_s.out_data;
    end else if (snap_ready) begin
      head_d = 1'b0;
    end
  end

  // The output stage keeps the stream pins straight from flip-flops.
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      head_q <= 1'b0;
      word_q <= '0;
    end else begin
      head_q <= head_d;
      word_q <= word_d;
    end
  end

  snap_fifo #(.W(BSR_N), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .reset(reset),
    .s(snap_s)
  );

  assign snap_valid = head_q;
  assign snap_data = word_q;
  assign tdo = tdo_q;
  assign tdo_oe = oe_q;
  assign pad_cells = pad_q;
  assign ack_oe = ack_oe_q;
  assign test_mode = test_q;

endmodule : boundary_scan_tap

// *** tap_checker.sv ***
// Concurrent checks on the test access port pins.
`timescale 1ns/1ps
module tap_checker #(
  parameter int BSR_N = 107
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Port pins
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [BSR_N-1:0] pad_cells,
  input wire logic ack_oe,
  input wire logic test_mode,
  input wire logic snap_valid,
  input wire logic snap_ready,
  input wire logic [BSR_N-1:0] snap_data
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ============================================================
  // Assertions
  ack_inverse_a: assert property (
    !$past(reset) |-> ack_oe == !pad_cells[59])
    else $error("ack enable not inverse of its cell");
  irq_enable_a: assert property (!$past(reset) |-> pad_cells[57])
    else $error("irq enable cell not high");
  oe_trst_off_a: assert property (!trst_n |=> !tdo_oe)
    else $error("tdo driver on in test reset");
  mode_trst_off_a: assert property (!trst_n |-> ##2 !test_mode)
    else $error("test mode kept after test reset");
  tdo_on_fall_a: assert property (
    $changed(tdo) && trst_n |-> !$past(tck, 3))
    else $error("tdo moved outside a test clock low phase");
  oe_on_fall_a: assert property (
    $changed(tdo_oe) && trst_n && $past(trst_n) |-> !$past(tck, 3))
    else $error("tdo enable moved outside a test clock low phase");
  snap_hold_a: assert property (snap_valid && !snap_ready
    |=> snap_valid && $stable(snap_data))
    else $error("snapshot dropped before pop");
  snap_capture_a: assert property ($rose(snap_valid)
    |-> $past(tck, 3) && !test_mode)
    else $error("snapshot without sample capture");
  cover property (##1 $rose(tdo_oe));
  cover property (snap_valid && snap_ready);
  cover property (##1 $rose(test_mode));
endmodule : tap_checker

// *** jtag_host.sv ***
// Board tester model driving the test access port.
`timescale 1ns/1ps
module jtag_host (
  // Test access port
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo
);
  // Idle lines rest at the pull-up level, clock stands low.
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
    trst_n = 1'h1;
  end
  // ============================================================
  // One test clock period; returns tdo seen just before the rise.
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #24;
    o = tdo;
    tck = 1'h1;
    #24;
    tck = 1'h0;
  endtask : step
  // Idle to a shift state, n bits LSB first, then update and idle.
  task automatic scan(input bit ir, input int n, input logic [127:0] din,
    output logic [127:0] dout);
    logic o;
    #0.7;
    dout = '0;
    step(1'h1, 1'h1, o);
    if (ir) step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
    step(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'h1, 1'h1, o);
    step(1'h0, 1'h1, o);
  endtask : scan
  // Test reset pulse, then one step into idle.
  task automatic pulse_reset();
    logic o;
    #0.7;
    trst_n = 1'h0;
    #30;
    trst_n = 1'h1;
    #30;
    step(1'h0, 1'h1, o);
  endtask : pulse_reset
endmodule : jtag_host

// *** tb_top.sv ***
// Self-checking bench for the boundary-scan test access port.
`timescale 1ns/1ps
module tb_top;
  localparam int N = 107;
  localparam logic [N-1:0] IRQ = N'(1'h1) << 57;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic tck, tms, tdi, trst_n, tdo, tdo_oe, ack_oe, test_mode, snap_valid;
  logic snap_ready = 1'h0;
  logic [N-1:0] core_cells = '0;
  logic [N-1:0] pad_cells, snap_data;
  logic [127:0] dout;
  logic tdo_line;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  always #2 mclk = ~mclk;
  boundary_scan_tap #(.BSR_N(N), .FIFO_DEPTH(16)) u_dut (.mclk(mclk),
    .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe), .core_cells(core_cells),
    .pad_cells(pad_cells), .ack_oe(ack_oe), .test_mode(test_mode),
    .snap_valid(snap_valid), .snap_ready(snap_ready), .snap_data(snap_data));
  // A released data line shows the inverse, so a late enable is caught.
  assign tdo_line = tdo_oe ? tdo : !tdo;
  jtag_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo_line));
  // ============================================================
  // Reporting
  function automatic bit ok(input bit c);
    checks_done++;
    return c;
  endfunction : ok
  task automatic bad(input string m);
    miscompares++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : bad
  task automatic close_out();
    $display("miscompares=%0d checks_done=%0d", miscompares, checks_done);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out
  // ============================================================
  // Scenarios
  task automatic load_ir(input logic [1:0] code);
    u_host.scan(1'h1, 2, {126'h0, code}, dout);
    if (!ok(dout[1:0] === 2'h1)) bad("instruction capture");
  endtask : load_ir
  task automatic t_bypass();
    u_host.scan(1'h0, 4, 128'hb, dout);
    if (!ok(dout[3:0] === 4'h6)) bad("bypass path");
    if (!ok(tdo_oe === 1'h0)) bad("tdo driver left on");
  endtask : t_bypass
  task automatic t_sample(input logic [1:0] code, input logic [N-1:0] p);
    load_ir(code);
    @(posedge mclk) core_cells <= p;
    u_host.scan(1'h0, N, 128'h0, dout);
    if (!ok(dout[N-1:0] === p)) bad("sample shift out");
    if (!ok(pad_cells === (p | IRQ))) bad("pads disturbed");
    if (!ok(snap_valid === 1'h1 && snap_data === p)) bad("snapshot");
    @(posedge mclk) snap_ready <= 1'h1;
    @(posedge mclk) snap_ready <= 1'h0;
  endtask : t_sample
  task automatic t_extest(input logic [N-1:0] p);
    load_ir(2'h1);
    u_host.scan(1'h0, N, 128'(p), dout);
    @(posedge mclk) snap_ready <= 1'h1;
    @(posedge mclk) snap_ready <= 1'h0;
    load_ir(2'h0);
    if (!ok(test_mode === 1'h1)) bad("test mode off");
    if (!ok(pad_cells === (p | IRQ))) bad("preload pads");
    if (!ok(ack_oe === !p[59])) bad("ack enable");
    u_host.scan(1'h0, N, 128'h0, dout);
    if (!ok(pad_cells === IRQ)) bad("zeros not tristate");
    u_host.pulse_reset();
    if (!ok(test_mode === 1'h0)) bad("test reset kept mode");
    if (!ok(pad_cells === (core_cells | IRQ))) bad("core pads");
    t_bypass();
  endtask : t_extest
  task automatic t_fifo();
    load_ir(2'h2);
    for (int i = 0; i < 17; i++) begin
      @(posedge mclk) core_cells <= N'(i);
      u_host.scan(1'h0, 1, 128'h0, dout);
    end
    for (int i = 0; i < 17; i++) begin
      @(negedge mclk);
      if (!ok(snap_data === N'(i))) bad("fifo order");
      @(posedge mclk) snap_ready <= 1'h1;
      @(posedge mclk) snap_ready <= 1'h0;
    end
    @(negedge mclk);
    if (!ok(snap_valid === 1'h0)) bad("fifo not empty");
  endtask : t_fifo
  // ============================================================
  // Main sequence and timeout
  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'h0;
    repeat (4) @(posedge mclk);
    u_host.pulse_reset();
    t_bypass();
    load_ir(2'h3);
    t_bypass();
    t_sample(2'h1, {1'h1, {53{2'h1}}});
    t_sample(2'h2, {1'h0, {53{2'h2}}});
    t_extest({7'h55, {25{4'hc}}});
    t_fifo();
    close_out();
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end
endmodule : tb_top

bind boundary_scan_tap tap_checker #(.BSR_N(BSR_N)) u_chk (.mclk(mclk),
  .reset(reset), .tck(tck), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe),
  .pad_cells(pad_cells), .ack_oe(ack_oe), .test_mode(test_mode),
  .snap_valid(snap_valid), .snap_ready(snap_ready), .snap_data(snap_data));
